// [core/mcrc_pkg.sv]
/*
 * Constants for the motor controller command and debug register bank:
 * byte offsets, field positions, widths and reset values.
 * Assumes a byte-addressed register port with 8-bit offsets.
 */
package mcrc_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] MCRC_OFF_DEV_CMD = 8'hea;
    localparam logic [7:0] MCRC_OFF_ALGO_A  = 8'hec;
    localparam logic [7:0] MCRC_OFF_ALGO_B  = 8'hee;
    localparam logic [7:0] MCRC_OFF_CUR_PI  = 8'hf0;
    localparam logic [7:0] MCRC_OFF_SPD_PI  = 8'hf2;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] MCRC_RST_WORD  = 32'h00000000;
    localparam logic [7:0]  MCRC_RST_KEY   = 8'h00;
    localparam logic [8:0]  MCRC_RST_ANGLE = 9'h000;
    localparam logic [14:0] MCRC_RST_SPEED = 15'h0000;
    localparam logic [9:0]  MCRC_RST_IQ    = 10'h000;
    localparam logic [3:0]  MCRC_RST_FORCE = 4'h0;

    // ****************************************************************
    // Device command word fields
    // ****************************************************************
    localparam int MCRC_DC_SAVE_BIT   = 31;
    localparam int MCRC_DC_RELOAD_BIT = 30;
    localparam int MCRC_DC_FCLR_BIT   = 29;
    localparam int MCRC_DC_RCLR_BIT   = 28;
    localparam int MCRC_DC_KEY_MSB    = 27;
    localparam int MCRC_DC_KEY_LSB    = 20;
    localparam int MCRC_DC_ANG_MSB    = 19;
    localparam int MCRC_DC_ANG_LSB    = 11;
    localparam int MCRC_DC_TICKLE_BIT = 10;

    // Angle wrap
    localparam logic [8:0] MCRC_FULL_TURN = 9'h168;

    // ****************************************************************
    // Algorithm debug word A fields
    // ****************************************************************
    localparam int MCRC_AA_OVR_BIT    = 31;
    localparam int MCRC_AA_SPD_MSB    = 30;
    localparam int MCRC_AA_SPD_LSB    = 16;
    localparam int MCRC_AA_OPEN_BIT   = 15;
    localparam int MCRC_AA_FORCE_MSB  = 14;
    localparam int MCRC_AA_FORCE_LSB  = 11;
    localparam int MCRC_AA_ASRC_BIT   = 10;
    localparam int MCRC_AA_IQ_MSB     = 9;
    localparam int MCRC_AA_IQ_LSB     = 0;

endpackage : mcrc_pkg

// [core/mcrc_regs.sv]
/*
 * Command and debug register bank of the motor controller: one-shot
 * configuration save and reload requests, fault clears, keepalive
 * tickle, forced alignment angle, speed source override and the
 * debug and loop gain words.
 * Assumes the serial front end and the algorithm engine run on MCLK,
 * so no input here needs synchronising.
 */
//
// Summary of operation
// - Save bit one with matching key requests configuration store
// - Reload bit one requests default configuration load
// - Bits 29/28 pulse fault and retry clears
// - Write key field write-only, reads zero
// - Forced angle applied modulo 360 degrees
// - Device clears tickle bit once consumed
// - Debug words at ECh, EEh, reset zero
// - Gain words at F0h, F2h, reset zero
// - Debug word A write-only fields, zero reset
// - Override selects digital or input speed
// - Source select picks forced or stored angle
`timescale 1ns/1ns
module mcrc_regs
    import mcrc_pkg::*;
#(
    // Arbitrary neutral default for the save access key
    parameter logic [7:0] NVM_KEY_EXPECTED = 8'ha5
)
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // Register port
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    output logic      [31:0] REG_RDATA,
    output logic             REG_RVALID,
    // Nonvolatile memory engine
    output logic             NVM_SAVE_REQ,
    output logic             NVM_RELOAD_REQ,
    output logic      [7:0]  NVM_SAVE_KEY,
    input  wire logic        NVM_DONE,
    // Fault handling
    output logic             FAULT_CLEAR_ALL,
    output logic             RETRY_COUNTER_CLEAR,
    // Host keepalive
    output logic             KEEPALIVE_PENDING,
    input  wire logic        KEEPALIVE_ACK,
    // Speed command
    input  wire logic [14:0] SPEED_INPUT_CMD,
    output logic      [14:0] SPEED_CMD,
    output logic             SPEED_OVERRIDE,
    // Alignment and forcing
    input  wire logic [8:0]  ALIGN_ANGLE_STORED,
    output logic      [8:0]  ALIGN_ANGLE_APPLIED,
    output logic             OPEN_LOOP_SELECT,
    output logic      [3:0]  FORCE_STATE_EN,
    output logic             ALIGN_ANGLE_SOURCE_SELECT,
    output logic      [9:0]  FORCED_TORQUE_CURRENT_REF,
    // Debug and gain words
    output logic      [31:0] ALGO_DEBUG_B,
    output logic      [31:0] CURRENT_LOOP_GAINS,
    output logic      [31:0] SPEED_LOOP_GAINS
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire logic hit_dev   = (REG_ADDR == MCRC_OFF_DEV_CMD);
    wire logic hit_alga  = (REG_ADDR == MCRC_OFF_ALGO_A);
    wire logic hit_algb  = (REG_ADDR == MCRC_OFF_ALGO_B);
    wire logic hit_cur   = (REG_ADDR == MCRC_OFF_CUR_PI);
    wire logic hit_spd   = (REG_ADDR == MCRC_OFF_SPD_PI);

    wire logic wr_dev    = REG_WR & hit_dev;
    wire logic wr_alga   = REG_WR & hit_alga;
    wire logic wr_algb   = REG_WR & hit_algb;
    wire logic wr_cur    = REG_WR & hit_cur;
    wire logic wr_spd    = REG_WR & hit_spd;

    // ****************************************************************
    // Device command word
    // ****************************************************************
    wire logic [7:0] wr_key   = REG_WDATA[MCRC_DC_KEY_MSB:MCRC_DC_KEY_LSB];
    wire logic [8:0] wr_angle = REG_WDATA[MCRC_DC_ANG_MSB:MCRC_DC_ANG_LSB];

    wire logic key_ok     = (wr_key == NVM_KEY_EXPECTED);
    wire logic save_set   = wr_dev & REG_WDATA[MCRC_DC_SAVE_BIT] & key_ok;
    wire logic reload_set = wr_dev & REG_WDATA[MCRC_DC_RELOAD_BIT];
    wire logic tickle_set = wr_dev & REG_WDATA[MCRC_DC_TICKLE_BIT];

    logic       save_pend_q;
    logic       save_pend_d;
    logic       reload_pend_q;
    logic       reload_pend_d;
    logic       save_req_q;
    logic       reload_req_q;
    logic [7:0] key_q;
    logic       fclr_q;
    logic       rclr_q;
    logic [8:0] angle_q;
    logic       tickle_q;
    logic       tickle_d;

    // Pending bits read back high until the engine reports done
    assign save_pend_d   = save_set   | (save_pend_q   & ~NVM_DONE);
    assign reload_pend_d = reload_set | (reload_pend_q & ~NVM_DONE);
    assign tickle_d      = tickle_set | (tickle_q & ~KEEPALIVE_ACK);

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            save_pend_q   <= 1'b0;
            reload_pend_q <= 1'b0;
            save_req_q    <= 1'b0;
            reload_req_q  <= 1'b0;
            tickle_q      <= 1'b0;
        end
        else
        begin
            save_pend_q   <= save_pend_d;
            reload_pend_q <= reload_pend_d;
            save_req_q    <= save_set;
            reload_req_q  <= reload_set;
            tickle_q      <= tickle_d;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            fclr_q <= 1'b0;
            rclr_q <= 1'b0;
        end
        else
        begin
            fclr_q <= wr_dev & REG_WDATA[MCRC_DC_FCLR_BIT];
            rclr_q <= wr_dev & REG_WDATA[MCRC_DC_RCLR_BIT];
        end
    end

    // key held for engine, never read back
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            key_q   <= MCRC_RST_KEY;
            angle_q <= MCRC_RST_ANGLE;
        end
        else if (wr_dev)
        begin
            key_q   <= wr_key;
            angle_q <= wr_angle;
        end
    end

    // ****************************************************************
    // Algorithm debug word A
    // ****************************************************************
    logic        ovr_q;
    logic [14:0] dspeed_q;
    logic        open_q;
    logic [3:0]  force_q;
    logic        asrc_q;
    logic [9:0]  iq_q;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ovr_q    <= 1'b0;
            dspeed_q <= MCRC_RST_SPEED;
            open_q   <= 1'b0;
            force_q  <= MCRC_RST_FORCE;
            asrc_q   <= 1'b0;
            iq_q     <= MCRC_RST_IQ;
        end
        else if (wr_alga)
        begin
            ovr_q    <= REG_WDATA[MCRC_AA_OVR_BIT];
            dspeed_q <= REG_WDATA[MCRC_AA_SPD_MSB:MCRC_AA_SPD_LSB];
            open_q   <= REG_WDATA[MCRC_AA_OPEN_BIT];
            force_q  <= REG_WDATA[MCRC_AA_FORCE_MSB:MCRC_AA_FORCE_LSB];
            asrc_q   <= REG_WDATA[MCRC_AA_ASRC_BIT];
            iq_q     <= REG_WDATA[MCRC_AA_IQ_MSB:MCRC_AA_IQ_LSB];
        end
    end

    // ****************************************************************
    // Word registers B, current and speed gains
    // ****************************************************************
    logic [31:0] algb_q;
    logic [31:0] cur_q;
    logic [31:0] spd_q;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            algb_q <= MCRC_RST_WORD;
        else if (wr_algb)
            algb_q <= REG_WDATA;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            cur_q <= MCRC_RST_WORD;
            spd_q <= MCRC_RST_WORD;
        end
        else
        begin
            if (wr_cur)
                cur_q <= REG_WDATA;
            if (wr_spd)
                spd_q <= REG_WDATA;
        end
    end

    // ****************************************************************
    // Speed and angle selection
    // ****************************************************************
    // wrap angle to one turn
    wire logic       angle_wrap = (angle_q >= MCRC_FULL_TURN);
    wire logic [8:0] angle_mod  = angle_wrap ? (angle_q - MCRC_FULL_TURN) : angle_q;
    wire logic [8:0] angle_sel  = asrc_q ? angle_mod : ALIGN_ANGLE_STORED;
    wire logic [14:0] speed_sel = ovr_q ? dspeed_q : SPEED_INPUT_CMD;

    logic [14:0] speed_q;
    logic [8:0]  align_q;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            speed_q <= MCRC_RST_SPEED;
            align_q <= MCRC_RST_ANGLE;
        end
        else
        begin
            speed_q <= speed_sel;
            align_q <= angle_sel;
        end
    end

    // ****************************************************************
    // Read back
    // ****************************************************************
    // key, angle and clears read zero
    wire logic [31:0] dev_rd = {save_pend_q, reload_pend_q, 19'h00000,
                                tickle_q, 10'h000};
    // Write-only words and unmapped offsets read zero
    wire logic [31:0] rd_mux = hit_dev  ? dev_rd :
                               hit_algb ? algb_q :
                               hit_cur  ? cur_q  :
                               hit_spd  ? spd_q  : MCRC_RST_WORD;

    logic [31:0] rdata_q;
    logic        rvalid_q;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            rdata_q  <= MCRC_RST_WORD;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= REG_RD;
            if (REG_RD)
                rdata_q <= rd_mux;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign REG_RDATA                 = rdata_q;
    assign REG_RVALID                = rvalid_q;
    assign NVM_SAVE_REQ              = save_req_q;
    assign NVM_RELOAD_REQ            = reload_req_q;
    assign NVM_SAVE_KEY              = key_q;
    assign FAULT_CLEAR_ALL           = fclr_q;
    assign RETRY_COUNTER_CLEAR       = rclr_q;
    assign KEEPALIVE_PENDING         = tickle_q;
    assign SPEED_CMD                 = speed_q;
    assign SPEED_OVERRIDE            = ovr_q;
    assign ALIGN_ANGLE_APPLIED       = align_q;
    assign OPEN_LOOP_SELECT          = open_q;
    assign FORCE_STATE_EN            = force_q;
    assign ALIGN_ANGLE_SOURCE_SELECT = asrc_q;
    assign FORCED_TORQUE_CURRENT_REF = iq_q;
    assign ALGO_DEBUG_B              = algb_q;
    assign CURRENT_LOOP_GAINS        = cur_q;
    assign SPEED_LOOP_GAINS          = spd_q;

endmodule : mcrc_regs

// [tb/mcrc_regs_assertions.sv]
/* Checker for the command and debug register bank.
   Bound to mcrc_regs, sees only its ports. */
`timescale 1ns/1ns
module mcrc_regs_assertions
    import mcrc_pkg::*;
#(
    parameter logic [7:0] NVM_KEY_EXPECTED = 8'ha5
)
(
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST,
    // Register port
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    input wire logic        REG_RVALID,
    // Engine side
    input wire logic        NVM_SAVE_REQ,
    input wire logic        NVM_RELOAD_REQ,
    input wire logic        FAULT_CLEAR_ALL,
    input wire logic        RETRY_COUNTER_CLEAR,
    input wire logic        KEEPALIVE_PENDING,
    input wire logic        KEEPALIVE_ACK,
    // Speed and angle
    input wire logic [14:0] SPEED_INPUT_CMD,
    input wire logic [14:0] SPEED_CMD,
    input wire logic        SPEED_OVERRIDE,
    input wire logic [8:0]  ALIGN_ANGLE_STORED,
    input wire logic [8:0]  ALIGN_ANGLE_APPLIED,
    input wire logic        ALIGN_ANGLE_SOURCE_SELECT
);
    logic wr_dev, wr_a, save_w, fclr_w, rclr_w, tick_w;
    assign wr_dev = REG_WR && (REG_ADDR == MCRC_OFF_DEV_CMD);
    assign wr_a   = REG_WR && (REG_ADDR == MCRC_OFF_ALGO_A);
    assign save_w = wr_dev && REG_WDATA[31] && (REG_WDATA[27:20] == NVM_KEY_EXPECTED);
    assign fclr_w = wr_dev && REG_WDATA[29];
    assign rclr_w = wr_dev && REG_WDATA[28];
    assign tick_w = wr_dev && REG_WDATA[10];
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    property p_save; save_w |=> NVM_SAVE_REQ; endproperty
    a_save: assert property (p_save) else $error("save pulse missing");
    property p_nokey; !save_w |=> !NVM_SAVE_REQ; endproperty
    a_nokey: assert property (p_nokey) else $error("save without key");
    property p_reload; wr_dev && REG_WDATA[30] |=> NVM_RELOAD_REQ; endproperty
    a_reload: assert property (p_reload) else $error("reload pulse missing");
    property p_fclr; FAULT_CLEAR_ALL == $past(fclr_w); endproperty
    a_fclr: assert property (p_fclr) else $error("fault clear pulse wrong");
    property p_rclr; RETRY_COUNTER_CLEAR == $past(rclr_w); endproperty
    a_rclr: assert property (p_rclr) else $error("retry clear pulse wrong");
    property p_tset; tick_w |=> KEEPALIVE_PENDING; endproperty
    a_tset: assert property (p_tset) else $error("tickle not held");
    property p_tclr; KEEPALIVE_ACK && !tick_w |=> !KEEPALIVE_PENDING; endproperty
    a_tclr: assert property (p_tclr) else $error("tickle not cleared");
    property p_spd; !SPEED_OVERRIDE && !wr_a |=> SPEED_CMD == $past(SPEED_INPUT_CMD); endproperty
    a_spd: assert property (p_spd) else $error("speed source wrong");
    property p_ang;
        !ALIGN_ANGLE_SOURCE_SELECT && !wr_a |=> ALIGN_ANGLE_APPLIED == $past(ALIGN_ANGLE_STORED);
    endproperty
    a_ang: assert property (p_ang) else $error("stored angle not used");
    property p_rda;
        REG_RD && REG_ADDR == MCRC_OFF_ALGO_A |=> REG_RVALID && REG_RDATA == 32'h0;
    endproperty
    a_rda: assert property (p_rda) else $error("debug word A read not zero");
    c_save: cover property (NVM_SAVE_REQ);
    c_ack: cover property (KEEPALIVE_ACK);
    c_ovr: cover property (SPEED_OVERRIDE);
endmodule : mcrc_regs_assertions

// [tb/mcrc_engine_model.sv]
/* Engine model: answers save, reload and keepalive requests.
   SLOW selects a long or a short answer delay. */
`timescale 1ns/1ns
module mcrc_engine_model
(
    // Clock, reset, pacing
    input  wire logic MCLK,
    input  wire logic RST,
    input  wire logic SLOW,
    // Requests
    input  wire logic NVM_SAVE_REQ,
    input  wire logic NVM_RELOAD_REQ,
    input  wire logic KEEPALIVE_PENDING,
    // Answers
    output logic      NVM_DONE,
    output logic      KEEPALIVE_ACK
);
    logic [3:0] nvm_q, ka_q, lim;
    assign lim           = SLOW ? 4'ha : 4'h2;
    assign NVM_DONE      = nvm_q == 4'h1;
    assign KEEPALIVE_ACK = KEEPALIVE_PENDING && (ka_q == lim);
    always_ff @(posedge MCLK or posedge RST)
        if (RST)
        begin
            nvm_q <= 4'h0;
            ka_q  <= 4'h0;
        end
        else
        begin
            nvm_q <= (NVM_SAVE_REQ || NVM_RELOAD_REQ) ? lim : nvm_q - {3'h0, nvm_q != 4'h0};
            ka_q  <= (KEEPALIVE_ACK || !KEEPALIVE_PENDING) ? 4'h0 : ka_q + 4'h1;
        end
endmodule : mcrc_engine_model

// [tb/mcrc_regs_tb_top.sv]
/* Self-checking bench of the command and debug register bank.
   Acts as host on the register port; the engine model answers. */
`timescale 1ns/1ns
module mcrc_regs_tb_top
    import mcrc_pkg::*;
#(
    parameter logic [7:0] KEY = 8'ha5
);
    logic        MCLK, RST, REG_WR, REG_RD, REG_RVALID, NVM_DONE, KEEPALIVE_ACK, slow;
    logic        NVM_SAVE_REQ, NVM_RELOAD_REQ, FAULT_CLEAR_ALL, RETRY_COUNTER_CLEAR;
    logic        KEEPALIVE_PENDING, SPEED_OVERRIDE, OPEN_LOOP_SELECT, ALIGN_ANGLE_SOURCE_SELECT;
    logic [7:0]  REG_ADDR, NVM_SAVE_KEY;
    logic [3:0]  FORCE_STATE_EN;
    logic [8:0]  ALIGN_ANGLE_STORED, ALIGN_ANGLE_APPLIED;
    logic [9:0]  FORCED_TORQUE_CURRENT_REF;
    logic [14:0] SPEED_INPUT_CMD, SPEED_CMD;
    logic [31:0] REG_WDATA, REG_RDATA, ALGO_DEBUG_B, CURRENT_LOOP_GAINS, SPEED_LOOP_GAINS, d;
    logic [31:0] seed = 32'hf6aae641;
    logic [31:0] exp_q [$];
    logic [7:0]  offs [6] = '{8'hea, 8'hec, 8'hee, 8'hf0, 8'hf2, 8'he9};
    int          angs [4] = '{0, 359, 360, 511};
    int          fails = 0;
    int          tests_run = 0;

    mcrc_regs #(.NVM_KEY_EXPECTED(KEY)) dut_u (.MCLK, .RST, .REG_WR, .REG_RD, .REG_ADDR,
        .REG_WDATA, .REG_RDATA, .REG_RVALID, .NVM_SAVE_REQ, .NVM_RELOAD_REQ, .NVM_SAVE_KEY,
        .NVM_DONE, .FAULT_CLEAR_ALL, .RETRY_COUNTER_CLEAR, .KEEPALIVE_PENDING, .KEEPALIVE_ACK,
        .SPEED_INPUT_CMD, .SPEED_CMD, .SPEED_OVERRIDE, .ALIGN_ANGLE_STORED, .ALIGN_ANGLE_APPLIED,
        .OPEN_LOOP_SELECT, .FORCE_STATE_EN, .ALIGN_ANGLE_SOURCE_SELECT, .FORCED_TORQUE_CURRENT_REF,
        .ALGO_DEBUG_B, .CURRENT_LOOP_GAINS, .SPEED_LOOP_GAINS);
    mcrc_engine_model eng_u (.MCLK, .RST, .SLOW(slow), .NVM_SAVE_REQ, .NVM_RELOAD_REQ,
        .KEEPALIVE_PENDING, .NVM_DONE, .KEEPALIVE_ACK);

    always #4 MCLK = ~MCLK;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        cyc(1);
        REG_WR    = 1'b1;
        REG_ADDR  = a;
        REG_WDATA = v;
        cyc(1);
        REG_WR = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        cyc(1);
        REG_RD   = 1'b1;
        REG_ADDR = a;
        exp_q.push_back(e);
        cyc(1);
        REG_RD = 1'b0;
    endtask : rd

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // Read results are matched against the oldest expectation
    always @(negedge MCLK)
        if (REG_RVALID === 1'b1)
            chk(REG_RDATA, exp_q.pop_front());

    initial
    begin
        repeat (5000) @(posedge MCLK);
        fails++;
        wrap_up();
    end

    initial
    begin
        {MCLK, RST, REG_WR, REG_RD, slow, REG_ADDR} = {5'h08, 8'h00};
        REG_WDATA          = 32'h0;
        SPEED_INPUT_CMD    = xs() >> 17;
        ALIGN_ANGLE_STORED = xs() >> 23;
        repeat (12) @(posedge MCLK);
        #1;
        RST = 1'b0;
        foreach (offs[i]) rd(offs[i], 32'h0);
        for (int i = 2; i < 5; i++)
        begin
            d = xs();
            wr(offs[i], d);
            chk((i == 2) ? ALGO_DEBUG_B : (i == 3) ? CURRENT_LOOP_GAINS : SPEED_LOOP_GAINS, d);
            rd(offs[i], d);
        end
        // Reserved offsets are only read, never written
        rd(offs[5], 32'h0);
        $display("test registers done");
        wr(8'hea, 32'h3000_0000);
        chk(32'({FAULT_CLEAR_ALL, RETRY_COUNTER_CLEAR}), 32'h3);
        cyc(1);
        chk(32'({FAULT_CLEAR_ALL, RETRY_COUNTER_CLEAR}), 32'h0);
        wr(8'hea, 32'h83c0_0000);
        rd(8'hea, 32'h0);
        slow = 1'b1;
        wr(8'hea, {4'hc, KEY, 20'h0});
        chk(32'({NVM_SAVE_REQ, NVM_SAVE_KEY}), {23'h0, 1'b1, KEY});
        rd(8'hea, 32'hc000_0000);
        cyc(14);
        rd(8'hea, 32'h0);
        wr(8'hea, 32'h400);
        rd(8'hea, 32'h400);
        cyc(14);
        rd(8'hea, 32'h0);
        slow = 1'b0;
        wr(8'hea, 32'h4000_0000);
        chk(32'(NVM_RELOAD_REQ), 32'h1);
        cyc(5);
        rd(8'hea, 32'h0);
        $display("test commands done");
        wr(8'hec, 32'h400);
        foreach (angs[i])
        begin
            wr(8'hea, 32'(angs[i]) << 11);
            cyc(2);
            chk(32'(ALIGN_ANGLE_APPLIED), 32'(angs[i] % 360));
        end
        d = xs() | 32'h8000_0000;
        wr(8'hec, d);
        cyc(2);
        chk(32'({SPEED_OVERRIDE, SPEED_CMD}), 32'({1'b1, d[30:16]}));
        chk(32'({OPEN_LOOP_SELECT, FORCE_STATE_EN, ALIGN_ANGLE_SOURCE_SELECT,
            FORCED_TORQUE_CURRENT_REF}), 32'(d[15:0]));
        rd(8'hec, 32'h0);
        wr(8'hec, 32'h0);
        cyc(2);
        chk(32'({SPEED_CMD, ALIGN_ANGLE_APPLIED}),
            32'({SPEED_INPUT_CMD, ALIGN_ANGLE_STORED}));
        $display("test forcing done");
        cyc(4);
        wrap_up();
    end
endmodule : mcrc_regs_tb_top

bind mcrc_regs mcrc_regs_assertions #(.NVM_KEY_EXPECTED(NVM_KEY_EXPECTED)) chk_u (.MCLK, .RST,
    .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_RVALID, .NVM_SAVE_REQ,
    .NVM_RELOAD_REQ, .FAULT_CLEAR_ALL, .RETRY_COUNTER_CLEAR, .KEEPALIVE_PENDING, .KEEPALIVE_ACK,
    .SPEED_INPUT_CMD, .SPEED_CMD, .SPEED_OVERRIDE, .ALIGN_ANGLE_STORED, .ALIGN_ANGLE_APPLIED,
    .ALIGN_ANGLE_SOURCE_SELECT);
